// >>> logic/spb_consts.vh
`ifndef SPB_CONSTS_VH
`define SPB_CONSTS_VH
`define SPB_BOOT_ADDR 32'h20000000
`define SPB_A_SERIAL_DATA 32'h10000000
`define SPB_A_LINE_STATUS 32'h10000005
`define SPB_A_BAUD_DIV 32'h1000000C
`define SPB_A_BAUD_DIV_ALT 32'h10000010
`define SPB_A_CPU_FREQ 32'h10000014
`define SPB_A_MEM_SIZE 32'h10000018
`define SPB_A_PIN_DIR 32'h10000700
`define SPB_A_PIN_OUT 32'h10000704
`define SPB_A_PIN_IN 32'h10000708
`define SPB_A_SPI_CTRL 32'h10500000
`define SPB_A_SPI_DATA 32'h10500004
`define SPB_A_PSRAM_CTRL 32'h10600000
`define SPB_A_CPU_CTRL 32'h11100000
`define SPB_KEY_RESET 32'h00007777
`define SPB_KEY_HALT 32'h00005555
`define SPB_PIN_OUT_BIT 9
`define SPB_RST_DIV 32'h000000AD
`define SPB_CPU_FREQ_Q88 32'h00001400
`define SPB_MEM_SIZE 32'h02000000
`endif

// >>> logic/spb_rd_reg.v
`timescale 1ns/1ps
// registered read-data holder: load data land one cycle after the request
module spb_rd_reg #(
    parameter W = 32
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    always @(posedge clk) begin
        if (rst) begin
            dout <= {W{1'b0}};
        end else if (load) begin
            dout <= din;
        end
    end
endmodule

// >>> logic/spb_regbank.v
`timescale 1ns/1ps
`include "spb_consts.vh"
// ==========================================
module spb_regbank (
    input wire CLK,
    input wire RST,
    input wire REQ_VALID,
    input wire REQ_WRITE,
    input wire [31:0] REQ_ADDR,
    input wire [31:0] REQ_WDATA,
    output reg [31:0] RDATA,
    output reg RVALID,
    output reg [31:0] BOOT_ADDR,
    output reg CPU_RESET_PULSE,
    output reg CPU_HALTED,
    output reg TX_VALID,
    output reg [7:0] TX_BYTE,
    input wire RX_VALID,
    input wire [7:0] RX_BYTE,
    input wire [7:0] LINE_STATUS,
    output reg [31:0] BAUD_DIV,
    output reg [31:0] BAUD_DIV_ALT,
    output reg [31:0] SPI_CTRL,
    output reg [31:0] SPI_DATA,
    output reg SPI_DATA_WR,
    input wire [31:0] SPI_RDATA,
    output reg PSRAM_HALF_CLOCK,
    output reg PSRAM_CLK,
    input wire [7:0] DEDICATED_INPUTS,
    output reg DEDICATED_OUT1
);
    // ==========================================
    // input synchronisers
    reg [7:0] pin_s1_ff;
    reg [7:0] pin_s2_ff;
    reg [7:0] lsr_s1_ff;
    reg [7:0] lsr_s2_ff;
    always @(posedge CLK) begin
        if (RST) begin
            pin_s1_ff <= 8'h00;
            pin_s2_ff <= 8'h00;
        end else begin
            pin_s1_ff <= DEDICATED_INPUTS;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            lsr_s1_ff <= 8'h00;
            lsr_s2_ff <= 8'h00;
        end else begin
            lsr_s1_ff <= LINE_STATUS;
            lsr_s2_ff <= lsr_s1_ff;
        end
    end

    // ==========================================
    // decode
    // line status sits at byte 5: the word at 0x10000004 shows it in bits 15:8
    function hit;
        input [31:0] a;
        input [31:0] base;
        begin
            hit = (a[31:2] == base[31:2]);
        end
    endfunction

    function [29:0] word_of;
        input [31:0] a;
        begin
            word_of = a[31:2];
        end
    endfunction

    wire wr = REQ_VALID & REQ_WRITE;
    wire rd = REQ_VALID & ~REQ_WRITE;

    reg [7:0] rx_hold_ff;
    reg [31:0] pin_dir_ff;
    reg [31:0] pin_out_ff;
    reg [1:0] pdiv_ff;

    // ==========================================
    // address decode
    wire sel_data = hit(REQ_ADDR, `SPB_A_SERIAL_DATA);
    wire sel_div = hit(REQ_ADDR, `SPB_A_BAUD_DIV);
    wire sel_div_alt = hit(REQ_ADDR, `SPB_A_BAUD_DIV_ALT);
    wire sel_pdir = hit(REQ_ADDR, `SPB_A_PIN_DIR);
    wire sel_pout = hit(REQ_ADDR, `SPB_A_PIN_OUT);
    wire sel_spic = hit(REQ_ADDR, `SPB_A_SPI_CTRL);
    wire sel_spid = hit(REQ_ADDR, `SPB_A_SPI_DATA);
    wire sel_psram = hit(REQ_ADDR, `SPB_A_PSRAM_CTRL);
    wire sel_cpu = hit(REQ_ADDR, `SPB_A_CPU_CTRL);
    wire wr_data = wr & sel_data;
    wire wr_div = wr & sel_div;
    wire wr_div_alt = wr & sel_div_alt;
    wire wr_pdir = wr & sel_pdir;
    wire wr_pout = wr & sel_pout;
    wire wr_spic = wr & sel_spic;
    wire wr_spid = wr & sel_spid;
    wire wr_psram = wr & sel_psram;
    wire wr_cpu = wr & sel_cpu;
    // full-word match: any other value written here matches neither key
    wire key_reset = wr_cpu & (REQ_WDATA == `SPB_KEY_RESET);
    wire key_halt = wr_cpu & (REQ_WDATA == `SPB_KEY_HALT);

    // ==========================================
    // boot vector
    always @(posedge CLK) begin
        if (RST) begin
            BOOT_ADDR <= `SPB_BOOT_ADDR;
        end else begin
            BOOT_ADDR <= `SPB_BOOT_ADDR;
        end
    end

    // ==========================================
    // serial port
    always @(posedge CLK) begin
        if (RST) begin
            TX_VALID <= 1'b0;
        end else begin
            TX_VALID <= wr_data;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            TX_BYTE <= 8'h00;
        end else if (wr_data) begin
            TX_BYTE <= REQ_WDATA[7:0];
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            rx_hold_ff <= 8'h00;
        end else if (RX_VALID) begin
            rx_hold_ff <= RX_BYTE;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            BAUD_DIV <= `SPB_RST_DIV;
        end else if (wr_div) begin
            BAUD_DIV <= REQ_WDATA;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            BAUD_DIV_ALT <= `SPB_RST_DIV;
        end else if (wr_div_alt) begin
            BAUD_DIV_ALT <= REQ_WDATA;
        end
    end

    // ==========================================
    // pins
    always @(posedge CLK) begin
        if (RST) begin
            pin_dir_ff <= 32'h00000000;
        end else if (wr_pdir) begin
            pin_dir_ff <= REQ_WDATA;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            pin_out_ff <= 32'h00000000;
        end else if (wr_pout) begin
            pin_out_ff <= REQ_WDATA;
        end
    end

    // direction never reaches this driver: the pin is output only
    always @(posedge CLK) begin
        if (RST) begin
            DEDICATED_OUT1 <= 1'b0;
        end else if (wr_pout) begin
            DEDICATED_OUT1 <= REQ_WDATA[`SPB_PIN_OUT_BIT];
        end
    end

    // ==========================================
    // serial peripheral
    always @(posedge CLK) begin
        if (RST) begin
            SPI_CTRL <= 32'h00000000;
        end else if (wr_spic) begin
            SPI_CTRL <= REQ_WDATA;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            SPI_DATA <= 32'h00000000;
        end else if (wr_spid) begin
            SPI_DATA <= REQ_WDATA;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            SPI_DATA_WR <= 1'b0;
        end else begin
            SPI_DATA_WR <= wr_spid;
        end
    end

    // ==========================================
    // psram clock select
    always @(posedge CLK) begin
        if (RST) begin
            PSRAM_HALF_CLOCK <= 1'b0;
        end else if (wr_psram) begin
            PSRAM_HALF_CLOCK <= REQ_WDATA[0];
        end
    end

    // ==========================================
    // processor control
    always @(posedge CLK) begin
        if (RST) begin
            CPU_RESET_PULSE <= 1'b0;
        end else begin
            CPU_RESET_PULSE <= key_reset;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            CPU_HALTED <= 1'b0;
        end else if (key_reset) begin
            CPU_HALTED <= 1'b0;
        end else if (key_halt) begin
            CPU_HALTED <= 1'b1;
        end
    end

    // ==========================================
    // psram clock divider
    always @(posedge CLK) begin
        if (RST) begin
            pdiv_ff <= 2'h0;
            PSRAM_CLK <= 1'b0;
        end else begin
            pdiv_ff <= pdiv_ff + 2'h1;
            PSRAM_CLK <= PSRAM_HALF_CLOCK ? pdiv_ff[1] : pdiv_ff[0];
        end
    end

    // ==========================================
    // read mux
    reg [31:0] nxt_rdata;
    always @* begin
        nxt_rdata = 32'h00000000;
        case (REQ_ADDR[31:2])
            word_of(`SPB_A_SERIAL_DATA): begin
                nxt_rdata = {24'h000000, rx_hold_ff};
            end
            word_of(`SPB_A_LINE_STATUS): begin
                nxt_rdata = {16'h0000, lsr_s2_ff, 8'h00};
            end
            word_of(`SPB_A_BAUD_DIV): begin
                nxt_rdata = BAUD_DIV;
            end
            word_of(`SPB_A_BAUD_DIV_ALT): begin
                nxt_rdata = BAUD_DIV_ALT;
            end
            word_of(`SPB_A_CPU_FREQ): begin
                nxt_rdata = `SPB_CPU_FREQ_Q88;
            end
            word_of(`SPB_A_MEM_SIZE): begin
                nxt_rdata = `SPB_MEM_SIZE;
            end
            word_of(`SPB_A_PIN_DIR): begin
                nxt_rdata = pin_dir_ff;
            end
            word_of(`SPB_A_PIN_OUT): begin
                nxt_rdata = pin_out_ff;
            end
            word_of(`SPB_A_PIN_IN): begin
                nxt_rdata = {24'h000000, pin_s2_ff};
            end
            word_of(`SPB_A_SPI_CTRL): begin
                nxt_rdata = SPI_CTRL;
            end
            word_of(`SPB_A_SPI_DATA): begin
                nxt_rdata = SPI_RDATA;
            end
            word_of(`SPB_A_PSRAM_CTRL): begin
                nxt_rdata = {31'h00000000, PSRAM_HALF_CLOCK};
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    wire [31:0] rd_q;
    spb_rd_reg #(
        .W(32)
    ) u_rd (
        .clk(CLK),
        .rst(RST),
        .load(rd),
        .din(nxt_rdata),
        .dout(rd_q)
    );

    always @* begin
        RDATA = rd_q;
    end

    always @(posedge CLK) begin
        if (RST) begin
            RVALID <= 1'b0;
        end else begin
            RVALID <= rd;
        end
    end
endmodule

// >>> verif/spb_cpu_model.sv
`timescale 1ns/1ps
module spb_cpu_model (
    input wire clk,
    output logic req_valid,
    output logic req_write,
    output logic [31:0] req_addr,
    output logic [31:0] req_wdata,
    input wire rvalid,
    input wire [31:0] rdata
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 32'h0;
        req_wdata = 32'h0;
    end
    task access(input logic w, input logic [31:0] a, input logic [31:0] d,
                output logic [31:0] q);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        // released bus inverted so a stale word never passes for a fresh one
        req_addr <= ~a;
        req_wdata <= ~d;
        #1;
        q = (rvalid === 1'b1) ? rdata : 32'hXXXXXXXX;
    endtask
endmodule

// >>> verif/spb_regbank_props.sv
`timescale 1ns/1ps
`include "spb_consts.vh"
module spb_regbank_props (
    input wire CLK,
    input wire RST,
    input wire REQ_VALID,
    input wire REQ_WRITE,
    input wire [31:0] REQ_ADDR,
    input wire [31:0] REQ_WDATA,
    input wire RVALID,
    input wire [31:0] BOOT_ADDR,
    input wire CPU_RESET_PULSE,
    input wire CPU_HALTED,
    input wire TX_VALID,
    input wire [7:0] TX_BYTE,
    input wire DEDICATED_OUT1,
    input wire PSRAM_HALF_CLOCK
);
    wire st = REQ_VALID && REQ_WRITE;
    wire ctl = st && REQ_ADDR == `SPB_A_CPU_CTRL;
    wire pout = st && REQ_ADDR == `SPB_A_PIN_OUT;
    wire [7:0] wd_lo = REQ_WDATA[7:0];
    wire wd9 = REQ_WDATA[9];
    wire wd0 = REQ_WDATA[0];
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    chk_boot_fixed:
    assert property (BOOT_ADDR == `SPB_BOOT_ADDR) else $error("boot address moved");
    chk_load_answer:
    assert property (REQ_VALID && !REQ_WRITE |=> RVALID) else $error("load not answered");
    chk_tx_store:
    assert property (st && REQ_ADDR == `SPB_A_SERIAL_DATA |=> TX_VALID && TX_BYTE == $past(wd_lo))
        else $error("serial byte not sent");
    chk_pin_out:
    assert property (pout |=> DEDICATED_OUT1 == $past(wd9)) else $error("output bit wrong");
    chk_dir_inert:
    assert property (st && REQ_ADDR == `SPB_A_PIN_DIR && !$past(pout) |=> $stable(DEDICATED_OUT1))
        else $error("direction moved output");
    chk_psram_sel:
    assert property (st && REQ_ADDR == `SPB_A_PSRAM_CTRL |=> PSRAM_HALF_CLOCK == $past(wd0))
        else $error("psram select wrong");
    chk_halt_key:
    assert property (ctl && REQ_WDATA == `SPB_KEY_HALT |=> CPU_HALTED) else $error("no halt");
    chk_reset_key:
    assert property (ctl && REQ_WDATA == `SPB_KEY_RESET |=> CPU_RESET_PULSE && !CPU_HALTED)
        else $error("no cpu reset");
    chk_other_kept:
    assert property (ctl && !$past(ctl) && REQ_WDATA != `SPB_KEY_HALT
        && REQ_WDATA != `SPB_KEY_RESET |=> !CPU_RESET_PULSE && $stable(CPU_HALTED))
        else $error("bad key acted");
endmodule

// >>> verif/spb_regbank_tb.sv
`timescale 1ns/1ps
`include "spb_consts.vh"
module spb_regbank_tb;
    logic CLK = 0;
    logic RST = 1;
    logic RX_VALID = 0;
    logic [7:0] RX_BYTE = 0, LINE_STATUS = 0, DEDICATED_INPUTS = 0;
    logic [31:0] SPI_RDATA = 0;
    logic REQ_VALID, REQ_WRITE, RVALID, CPU_RESET_PULSE, CPU_HALTED, TX_VALID;
    logic PSRAM_HALF_CLOCK, DEDICATED_OUT1, PSRAM_CLK, SPI_DATA_WR;
    logic [31:0] SPI_CTRL, SPI_DATA;
    logic [31:0] REQ_ADDR, REQ_WDATA, RDATA, BOOT_ADDR, BAUD_DIV, q;
    logic [7:0] TX_BYTE;
    int failures = 0;
    int n_tests = 0;
    always #25 CLK = ~CLK;
    spb_cpu_model u_spb_cpu_model (.clk(CLK), .req_valid(REQ_VALID), .req_write(REQ_WRITE),
        .req_addr(REQ_ADDR), .req_wdata(REQ_WDATA), .rvalid(RVALID), .rdata(RDATA));
    spb_regbank u_spb_regbank (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
        .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RDATA(RDATA),
        .RVALID(RVALID), .BOOT_ADDR(BOOT_ADDR), .CPU_RESET_PULSE(CPU_RESET_PULSE),
        .CPU_HALTED(CPU_HALTED), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .RX_VALID(RX_VALID),
        .RX_BYTE(RX_BYTE), .LINE_STATUS(LINE_STATUS), .BAUD_DIV(BAUD_DIV), .BAUD_DIV_ALT(),
        .SPI_CTRL(SPI_CTRL), .SPI_DATA(SPI_DATA), .SPI_DATA_WR(SPI_DATA_WR),
        .SPI_RDATA(SPI_RDATA), .PSRAM_HALF_CLOCK(PSRAM_HALF_CLOCK), .PSRAM_CLK(PSRAM_CLK),
        .DEDICATED_INPUTS(DEDICATED_INPUTS), .DEDICATED_OUT1(DEDICATED_OUT1));
    // ==========
    // helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd(input logic [31:0] a, input logic [31:0] exp);
        u_spb_cpu_model.access(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        u_spb_cpu_model.access(1'b1, a, d, q);
    endtask
    task psclk(input logic [31:0] exp);
        logic [31:0] n;
        logic p;
        n = 0;
        @(posedge CLK);
        #1 p = PSRAM_CLK;
        repeat (8) begin
            @(posedge CLK);
            #1;
            if (PSRAM_CLK !== p) n = n + 1;
            p = PSRAM_CLK;
        end
        chk(n, exp);
    endtask
    task summarize;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========
    // scenarios
    task t_info;
        chk(BOOT_ADDR, `SPB_BOOT_ADDR);
        rd(`SPB_A_BAUD_DIV, `SPB_RST_DIV);
        rd(`SPB_A_CPU_FREQ, `SPB_CPU_FREQ_Q88);
        rd(`SPB_A_MEM_SIZE, `SPB_MEM_SIZE);
        wr(`SPB_A_BAUD_DIV, 32'h00000123);
        chk(BAUD_DIV, 32'h00000123);
        wr(`SPB_A_BAUD_DIV_ALT, 32'h00000456);
        rd(`SPB_A_BAUD_DIV_ALT, 32'h00000456);
    endtask
    task t_serial;
        wr(`SPB_A_SERIAL_DATA, 32'h000001A5);
        chk({23'h0, TX_VALID, TX_BYTE}, 32'h000001A5);
        @(posedge CLK);
        RX_VALID <= 1'b1;
        RX_BYTE <= 8'h3C;
        LINE_STATUS <= 8'h61;
        @(posedge CLK);
        RX_VALID <= 1'b0;
        RX_BYTE <= 8'hC3;
        rd(`SPB_A_SERIAL_DATA, 32'h0000003C);
        u_spb_cpu_model.access(1'b0, `SPB_A_LINE_STATUS, 32'h0, q);
        chk({24'h0, q[15:8]}, 32'h00000061);
    endtask
    task t_pins;
        wr(`SPB_A_PIN_OUT, 32'h00000200);
        chk({31'h0, DEDICATED_OUT1}, 32'h1);
        wr(`SPB_A_PIN_DIR, 32'h00000000);
        chk({31'h0, DEDICATED_OUT1}, 32'h1);
        wr(`SPB_A_PIN_DIR, 32'hFFFFFFFF);
        rd(`SPB_A_PIN_DIR, 32'hFFFFFFFF);
        wr(`SPB_A_PIN_OUT, 32'hFFFFFDFF);
        chk({31'h0, DEDICATED_OUT1}, 32'h0);
        @(posedge CLK) DEDICATED_INPUTS <= 8'h84;
        repeat (2) @(posedge CLK);
        rd(`SPB_A_PIN_IN, 32'h00000084);
        @(posedge CLK) DEDICATED_INPUTS <= 8'h7B;
        repeat (2) @(posedge CLK);
        rd(`SPB_A_PIN_IN, 32'h0000007B);
    endtask
    task t_spi;
        wr(`SPB_A_SPI_CTRL, 32'h0000A5C3);
        rd(`SPB_A_SPI_CTRL, 32'h0000A5C3);
        wr(`SPB_A_SPI_DATA, 32'h0000005A);
        chk({SPI_DATA_WR, SPI_DATA[30:0]}, 32'h8000005A);
        chk(SPI_CTRL, 32'h0000A5C3);
        @(posedge CLK) SPI_RDATA <= 32'h000000E7;
        rd(`SPB_A_SPI_DATA, 32'h000000E7);
    endtask
    task t_ctl;
        wr(`SPB_A_PSRAM_CTRL, 32'h00000001);
        chk({31'h0, PSRAM_HALF_CLOCK}, 32'h1);
        psclk(32'h4);
        wr(`SPB_A_PSRAM_CTRL, 32'h00000000);
        chk({31'h0, PSRAM_HALF_CLOCK}, 32'h0);
        psclk(32'h8);
        wr(`SPB_A_CPU_CTRL, `SPB_KEY_HALT);
        chk({30'h0, CPU_RESET_PULSE, CPU_HALTED}, 32'h1);
        wr(`SPB_A_CPU_CTRL, 32'h00001234);
        chk({30'h0, CPU_RESET_PULSE, CPU_HALTED}, 32'h1);
        wr(`SPB_A_CPU_CTRL, `SPB_KEY_RESET);
        chk({30'h0, CPU_RESET_PULSE, CPU_HALTED}, 32'h2);
        wr(32'h10500008, 32'hFFFFFFFF);
        rd(32'h10500008, 32'h00000000);
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        t_info;
        t_serial;
        t_pins;
        t_spi;
        t_ctl;
        summarize;
    end
    initial begin
        repeat (3000) @(posedge CLK);
        failures++;
        summarize;
    end
endmodule
bind spb_regbank spb_regbank_props u_props (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .RVALID(RVALID),
    .BOOT_ADDR(BOOT_ADDR), .CPU_RESET_PULSE(CPU_RESET_PULSE), .CPU_HALTED(CPU_HALTED),
    .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .DEDICATED_OUT1(DEDICATED_OUT1),
    .PSRAM_HALF_CLOCK(PSRAM_HALF_CLOCK));
